// File: rtl/duv_pkg.sv
// Constants, types and carriers shared by the undervoltage and select bank.
package duv_pkg;

    // ****************************************************************
    // Sizes and register map
    // ****************************************************************
    localparam int        NUM_CH       = 8;
    localparam int        SEL_W        = 3;
    localparam int        DATA_W       = 8;
    localparam int        NUM_SEL_REGS = 4;
    localparam int        SEL_LO_LSB   = 0;
    localparam int        SEL_HI_LSB   = 3;
    localparam int        SEL_FIELDS_W = 2 * SEL_W;
    localparam logic [7:0] ADDR_UV       = 8'h27;
    localparam logic [7:0] ADDR_SEL_CH12 = 8'h28;
    localparam logic [7:0] ADDR_SEL_CH34 = 8'h29;
    localparam logic [7:0] ADDR_SEL_CH56 = 8'h2a;
    localparam logic [7:0] ADDR_SEL_CH78 = 8'h2b;
    localparam logic [7:0] UV_RESET      = 8'h00;
    localparam logic [5:0] SEL_RESET     = 6'h00;
    localparam logic [7:0] RDATA_IDLE    = 8'h00;

    // ****************************************************************
    // Source select encoding
    // ****************************************************************
    localparam logic [2:0] SEL_PIN     = 3'h0;
    localparam logic [2:0] SEL_TEMP    = 3'h1;
    localparam logic [2:0] SEL_REF     = 3'h2;
    localparam logic [2:0] SEL_AREG    = 3'h3;
    localparam logic [2:0] SEL_REG_ALT = 3'h4;
    localparam logic [2:0] SEL_IFACE   = 3'h5;
    localparam logic [2:0] SEL_GROUND  = 3'h6;
    localparam logic [2:0] SEL_ASUPPLY = 3'h7;

    typedef enum logic [2:0] {
        SRC_PIN,
        SRC_TEMP,
        SRC_REF_X4,
        SRC_AREG_X4,
        SRC_DREG_X4,
        SRC_IFACE_SUPPLY,
        SRC_ANALOG_GROUND,
        SRC_ASUPPLY
    } duv_source_t;

    // ****************************************************************
    // Register access carrier
    // ****************************************************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [7:0]        addr;
        logic [DATA_W-1:0] wdata;
    } duv_reg_req_t;

endpackage

// File: rtl/duv_source_decoder.sv
// Decodes one channel's source select into the routed analog source.
module duv_source_decoder
    import duv_pkg::*;
#(
    parameter bit ODD_CHANNEL = 1'b1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [SEL_W-1:0] sel_i,
    output duv_source_t           route_o
);

    duv_source_t route_reg;
    duv_source_t route_next;
    duv_source_t alt_source;

    // Code 100 names the digital regulator on odd channels only.
    assign alt_source = ODD_CHANNEL ? SRC_DREG_X4 : SRC_AREG_X4;

    always_comb begin
        unique case (sel_i)
            SEL_PIN:     route_next = SRC_PIN;
            SEL_TEMP:    route_next = SRC_TEMP;
            SEL_REF:     route_next = SRC_REF_X4;
            SEL_AREG:    route_next = SRC_AREG_X4;
            SEL_REG_ALT: route_next = alt_source;
            SEL_IFACE:   route_next = SRC_IFACE_SUPPLY;
            SEL_GROUND:  route_next = SRC_ANALOG_GROUND;
            SEL_ASUPPLY: route_next = SRC_ASUPPLY;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            route_reg <= SRC_PIN;
        end else begin
            route_reg <= route_next;
        end
    end

    assign route_o = route_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_pin_route: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sel_i == SEL_PIN |=> route_o == SRC_PIN)
        else $error("select 000 did not route the input pin");

    a_alt_route: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sel_i == SEL_REG_ALT |=>
            route_o == (ODD_CHANNEL ? SRC_DREG_X4 : SRC_AREG_X4))
        else $error("select 100 routed the wrong regulator");

    a_supply_route: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sel_i == SEL_ASUPPLY |=> route_o == SRC_ASUPPLY)
        else $error("select 111 did not route the analog supply");

endmodule

// File: rtl/duv_diag_bank.sv
// Undervoltage flags and per-channel source select register bank.
//
// Operation
// - Undervoltage flag register at 0x27, bit per channel.
// - Flags reset zero, read back, write-one clears.
// - Register 0x28: channel 2 [5:3], channel 1 [2:0].
// - Register 0x29: channel 4 upper, channel 3 lower.
// - Register 0x2a: channel 6 upper, channel 5 lower.
// - Select registers reset to zero, pin routed.
// - Select 000 routes the channel's own pin.
// - Select 001 routes the temperature sensor.
// - Select 010 routes four times reference.
// - Select 011 routes four times analog regulator.
// - Select 100: digital regulator odd, analog even.
// - Selects 101-111: interface supply, ground, supply.
// - Register 0x2b selects channels 7 and 8.
// - Flag sets only when channel check enabled.
// - Channel 8 select in [5:3], same encoding.
module duv_diag_bank
    import duv_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  duv_reg_req_t           reg_req_i,
    output logic [DATA_W-1:0]      reg_rdata_o,
    output logic                   reg_rvalid_o,
    input  wire logic [CHANNELS-1:0] uv_detect_i,
    input  wire logic [CHANNELS-1:0] voltage_check_enables_i,
    output logic [CHANNELS-1:0]    undervoltage_error_flags_o,
    output duv_source_t            route_o [CHANNELS]
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic is_sel_addr(input logic [7:0] addr);
        return (addr >= ADDR_SEL_CH12) && (addr <= ADDR_SEL_CH78);
    endfunction

    function automatic logic [1:0] sel_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - ADDR_SEL_CH12;
        return diff[1:0];
    endfunction

    wire logic       wr_uv;
    wire logic       wr_sel;
    wire logic       rd_uv;
    wire logic       rd_sel;
    wire logic [1:0] wr_idx;
    wire logic [1:0] rd_idx;

    assign wr_uv  = reg_req_i.wr && (reg_req_i.addr == ADDR_UV);
    assign rd_uv  = reg_req_i.rd && (reg_req_i.addr == ADDR_UV);
    assign wr_sel = reg_req_i.wr && is_sel_addr(reg_req_i.addr);
    assign rd_sel = reg_req_i.rd && is_sel_addr(reg_req_i.addr);
    assign wr_idx = sel_index(reg_req_i.addr);
    assign rd_idx = sel_index(reg_req_i.addr);

    // ****************************************************************
    // Undervoltage detector synchroniser
    // ****************************************************************
    logic [CHANNELS-1:0] uv_meta_reg;
    logic [CHANNELS-1:0] uv_sync_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            uv_meta_reg <= '0;
            uv_sync_reg <= '0;
        end else begin
            uv_meta_reg <= uv_detect_i;
            uv_sync_reg <= uv_meta_reg;
        end
    end

    // ****************************************************************
    // Undervoltage flags
    // ****************************************************************
    logic [CHANNELS-1:0] uv_flags_reg;
    logic [CHANNELS-1:0] uv_flags_next;
    wire  logic [CHANNELS-1:0] uv_set;
    wire  logic [CHANNELS-1:0] uv_clear;

    // Only channels with their check enabled can raise a flag.
    assign uv_set   = uv_sync_reg & voltage_check_enables_i;
    assign uv_clear = wr_uv ? reg_req_i.wdata[CHANNELS-1:0] : '0;
    // A detector event in the clearing cycle wins over the clear.
    assign uv_flags_next = (uv_flags_reg & ~uv_clear) | uv_set;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            uv_flags_reg <= UV_RESET[CHANNELS-1:0];
        end else begin
            uv_flags_reg <= uv_flags_next;
        end
    end

    assign undervoltage_error_flags_o = uv_flags_reg;

    // ****************************************************************
    // Source select registers
    // ****************************************************************
    logic [SEL_FIELDS_W-1:0] sel_reg [NUM_SEL_REGS];

    // Only the two select fields are stored; bits 7 and 6 drop.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_SEL_REGS; i++) begin
                sel_reg[i] <= SEL_RESET;
            end
        end else if (wr_sel) begin
            sel_reg[wr_idx] <= reg_req_i.wdata[SEL_FIELDS_W-1:0];
        end
    end

    // Odd channels take the lower field, even channels the upper one.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            wire logic [SEL_W-1:0] chan_sel;
            assign chan_sel = (ch % 2 == 0)
                ? sel_reg[ch/2][SEL_LO_LSB +: SEL_W]
                : sel_reg[ch/2][SEL_HI_LSB +: SEL_W];
            duv_source_decoder #(
                .ODD_CHANNEL ((ch % 2) == 0)
            ) u_decoder (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .sel_i     (chan_sel),
                .route_o   (route_o[ch])
            );
        end
    endgenerate

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [DATA_W-1:0] rdata_reg;
    logic              rvalid_reg;
    wire  logic [DATA_W-1:0] rdata_next;

    // Unmapped addresses read as zero; reserved select bits read zero.
    assign rdata_next = rd_uv  ? DATA_W'(uv_flags_reg) :
                        rd_sel ? DATA_W'(sel_reg[rd_idx]) :
                                 RDATA_IDLE;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg  <= RDATA_IDLE;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= reg_req_i.rd;
        end
    end

    assign reg_rdata_o  = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_clear_all;
        reg_req_i.wr && reg_req_i.addr == ADDR_UV
            && reg_req_i.wdata[CHANNELS-1:0] == '1;
    endsequence

    sequence s_no_event;
        uv_set == '0;
    endsequence

    a_uv_clear_w1c: assert property (
        s_clear_all and s_no_event |=> uv_flags_reg == '0)
        else $error("write one did not clear the flags");

    a_uv_flag_sticky: assert property (
        !wr_uv |=> (uv_flags_reg & $past(uv_flags_reg))
                   == $past(uv_flags_reg))
        else $error("flag dropped without a clearing write");

    a_uv_zero_keeps: assert property (
        wr_uv |=> (uv_flags_reg & $past(uv_flags_reg)
                   & ~$past(reg_req_i.wdata[CHANNELS-1:0]))
                  == ($past(uv_flags_reg)
                      & ~$past(reg_req_i.wdata[CHANNELS-1:0])))
        else $error("writing zero changed a flag");

    a_uv_set_gated: assert property (
        ##1 ((uv_flags_reg & ~$past(uv_flags_reg))
             & ~$past(voltage_check_enables_i)) == '0)
        else $error("flag set on a disabled channel");

    a_uv_read_back: assert property (
        rd_uv |=> reg_rvalid_o && reg_rdata_o == $past(uv_flags_reg))
        else $error("flag register read returned wrong data");

    a_sel_reserved_zero: assert property (
        rd_sel |=> reg_rdata_o[DATA_W-1:SEL_FIELDS_W] == '0)
        else $error("reserved select bits read non-zero");

    a_sel_ch34_write: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_SEL_CH34 |->
            ##2 route_o[2] == duv_source_t'($past(reg_req_i.wdata[2:0], 2))
                || $past(reg_req_i.wdata[2:0], 2) == SEL_REG_ALT)
        else $error("channel 3 select did not take effect");

    a_sel_ch78_write: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_SEL_CH78 ##1
            !(reg_req_i.wr && is_sel_addr(reg_req_i.addr)) |=>
            g_chan[7].chan_sel == $past(reg_req_i.wdata[5:3], 2))
        else $error("channel 8 select not in bits 5 to 3");

    a_sel_ch56_read: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_SEL_CH56 |=>
            reg_rdata_o[SEL_HI_LSB +: SEL_W] == $past(g_chan[5].chan_sel))
        else $error("channel 6 select read from wrong field");

    // ****************************************************************
    // Register map, flag and reset checks
    // ****************************************************************
    sequence s_sel_write(logic [7:0] addr_v);
        reg_req_i.wr && reg_req_i.addr == addr_v ##1 !wr_sel;
    endsequence

    a_sel_ch12_write: assert property (
        s_sel_write(ADDR_SEL_CH12) |=>
            g_chan[0].chan_sel == $past(reg_req_i.wdata[2:0], 2)
            && g_chan[1].chan_sel == $past(reg_req_i.wdata[5:3], 2))
        else $error("channel 1 or 2 select in the wrong field");

    a_sel_ch56_write: assert property (
        s_sel_write(ADDR_SEL_CH56) |=>
            g_chan[4].chan_sel == $past(reg_req_i.wdata[2:0], 2)
            && g_chan[5].chan_sel == $past(reg_req_i.wdata[5:3], 2))
        else $error("channel 5 or 6 select in the wrong field");

    a_sel_ch78_low: assert property (
        s_sel_write(ADDR_SEL_CH78) |=>
            g_chan[6].chan_sel == $past(reg_req_i.wdata[2:0], 2))
        else $error("channel 7 select not stored at its register");

    a_sel_ch12_read: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_SEL_CH12 |=>
            reg_rdata_o[SEL_LO_LSB +: SEL_W] == $past(g_chan[0].chan_sel))
        else $error("channel 1 select read from wrong field");

    a_sel_hold: assert property (
        !wr_sel |=> sel_reg[0] == $past(sel_reg[0])
                    && sel_reg[1] == $past(sel_reg[1])
                    && sel_reg[2] == $past(sel_reg[2])
                    && sel_reg[3] == $past(sel_reg[3]))
        else $error("select register changed without a write");

    a_sel_reset_zero: assert property (
        @(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> sel_reg[0] == SEL_RESET && sel_reg[1] == SEL_RESET
                       && sel_reg[2] == SEL_RESET)
        else $error("select registers not zero after reset");

    a_ch78_reset_zero: assert property (
        @(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> sel_reg[3] == SEL_RESET)
        else $error("channel 7 and 8 select not zero after reset");

    a_route_reset_pin: assert property (
        @(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> route_o[0] == SRC_PIN && route_o[1] == SRC_PIN
                       && route_o[2] == SRC_PIN && route_o[3] == SRC_PIN
                       && route_o[4] == SRC_PIN && route_o[5] == SRC_PIN
                       && route_o[6] == SRC_PIN && route_o[7] == SRC_PIN)
        else $error("a channel left reset away from its input pin");

    a_uv_reset_zero: assert property (
        @(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> uv_flags_reg == UV_RESET[CHANNELS-1:0])
        else $error("flags not zero after reset");

    a_uv_set_wins: assert property (
        uv_set != '0 |=> (uv_flags_reg & $past(uv_set)) == $past(uv_set))
        else $error("detector event lost to a clearing write");

    a_uv_rise_cause: assert property (
        ##1 (uv_flags_reg & ~$past(uv_flags_reg) & ~$past(uv_set)) == '0)
        else $error("flag set without a detector event");

    a_rvalid_pulse: assert property (
        ##1 reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read valid not one cycle after the read");

    a_unmapped_zero: assert property (
        reg_req_i.rd && !rd_uv && !rd_sel |=> reg_rdata_o == RDATA_IDLE)
        else $error("unmapped read returned non-zero data");

    a_idle_rdata_zero: assert property (
        !reg_req_i.rd |=> reg_rdata_o == RDATA_IDLE)
        else $error("read data not zero outside a read");

endmodule

// File: testbench/duv_host_model.sv
// Host controller model that issues register accesses to the bank.
module duv_host_model
    import duv_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    input  wire logic              rvalid_i,
    output duv_reg_req_t           req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // Holds the request up to the taking edge, then releases it with the
    // address and data inverted so that stale values are never reused.
    task automatic access(input logic wr, input logic rd,
                          input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic rvalid);
        @(posedge clk_i);
        req_o <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        rdata = rdata_i;
        rvalid = rvalid_i;
    endtask
endmodule

// File: testbench/duv_diag_bank_test.sv
// Self-checking bench for the undervoltage flag and source select bank.
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); \
        end \
    end

module duv_diag_bank_test
    import duv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk_i;
    logic         reset_n_i;
    duv_reg_req_t req;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [7:0]   uv_det;
    logic [7:0]   enables;
    logic [7:0]   flags;
    duv_source_t  route [NUM_CH];
    int           fail_count = 0;
    int           checks_done = 0;
    int           cycles = 0;
    logic [31:0]  seed = 32'h6fa93772;
    logic [31:0]  r;
    logic [7:0]   rd_v;
    logic         rv_v;
    logic [7:0]   exp_flags;
    logic [7:0]   mask;
    int           k;

    duv_diag_bank #(.CHANNELS(NUM_CH)) u_dut (
        .clk_i                      (clk_i),
        .reset_n_i                  (reset_n_i),
        .reg_req_i                  (req),
        .reg_rdata_o                (rdata),
        .reg_rvalid_o               (rvalid),
        .uv_detect_i                (uv_det),
        .voltage_check_enables_i    (enables),
        .undervoltage_error_flags_o (flags),
        .route_o                    (route)
    );

    duv_host_model u_host (
        .clk_i    (clk_i),
        .rdata_i  (rdata),
        .rvalid_i (rvalid),
        .req_o    (req)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Code 100 picks the digital regulator on odd channels only.
    function automatic duv_source_t exp_src(int ch, logic [2:0] code);
        if (code == 3'h4) return (ch % 2 == 0) ? SRC_DREG_X4 : SRC_AREG_X4;
        return duv_source_t'(code);
    endfunction

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        u_host.access(1'b0, 1'b1, addr, 8'h00, rd_v, rv_v);
        `CHK(rv_v, 1'b1)
        `CHK(rd_v, exp)
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_host.access(1'b1, 1'b0, addr, data, rd_v, rv_v);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        reset_n_i = 1'b0;
        uv_det = 8'h00;
        enables = 8'h00;
        exp_flags = 8'h00;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd_chk(ADDR_UV, UV_RESET);
        for (k = 1; k < 5; k++) rd_chk(ADDR_UV + 8'(k), 8'h00);
        for (k = 0; k < NUM_CH; k++) `CHK(route[k], SRC_PIN)
        $display("test reset done");
        for (int code = 0; code < 8; code++) begin
            for (k = 0; k < NUM_SEL_REGS; k++) begin
                wr(ADDR_SEL_CH12 + 8'(k), {2'b11, 3'(code), 3'(code)});
            end
            @(posedge clk_i);
            #1;
            for (k = 0; k < NUM_CH; k++) begin
                `CHK(route[k], exp_src(k, 3'(code)))
            end
        end
        $display("test source codes done");
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            k = int'(r[9:8]);
            wr(ADDR_SEL_CH12 + 8'(k), r[7:0]);
            rd_chk(ADDR_SEL_CH12 + 8'(k), r[7:0] & 8'h3f);
            `CHK(route[2*k], exp_src(2*k, r[2:0]))
            `CHK(route[2*k+1], exp_src(2*k+1, r[5:3]))
        end
        $display("test field placement done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            @(posedge clk_i);
            enables <= r[7:0];
            uv_det <= r[15:8];
            exp_flags = exp_flags | (r[7:0] & r[15:8]);
            repeat (4) @(posedge clk_i);
            uv_det <= 8'h00;
            repeat (4) @(posedge clk_i);
            #1;
            `CHK(flags, exp_flags)
            rd_chk(ADDR_UV, exp_flags);
            mask = (i == 0) ? 8'h00 : r[23:16];
            wr(ADDR_UV, mask);
            exp_flags = exp_flags & ~mask;
            `CHK(flags, exp_flags)
        end
        @(posedge clk_i);
        enables <= 8'h01;
        uv_det <= 8'h01;
        repeat (4) @(posedge clk_i);
        wr(ADDR_UV, 8'h01);
        `CHK(flags[0], 1'b1)
        @(posedge clk_i);
        uv_det <= 8'h00;
        repeat (4) @(posedge clk_i);
        wr(ADDR_UV, 8'h01);
        `CHK(flags[0], 1'b0)
        $display("test undervoltage flags done");
        wr(ADDR_SEL_CH12, 8'h15);
        wr(8'h2c, 8'hff);
        rd_chk(ADDR_SEL_CH12, 8'h15);
        rd_chk(8'h26, RDATA_IDLE);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK(flags, UV_RESET)
        `CHK(route[1], SRC_PIN)
        $display("test unmapped and reset done");
        results();
    end
endmodule
